//--- rtl/nand_ecc_acc.sv
// Page ECC accumulator: parity plus XOR of the positions of all set bits.
`timescale 1ns/1ps

module nand_ecc_acc #(
	parameter int IDX_W = 11
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clear,
	input wire logic valid,
	input wire logic [7:0] data,
	input wire logic [IDX_W-1:0] idx,
	output logic [IDX_W+3:0] code
);

	// ======================================================================
	// Per-bit position folding
	logic [2:0] bitpos [0:8];
	assign bitpos[0] = 3'h0;
	genvar g;
	for (g = 0; g < 8; g++) begin : fold
		assign bitpos[g+1] = bitpos[g] ^ (data[g] ? 3'(g) : 3'h0);
	end

	wire par = ^data;
	wire [IDX_W+3:0] contrib = {par, idx & {IDX_W{par}}, bitpos[8]};

	// ======================================================================
	// Accumulator
	always_ff @(posedge clock) begin
		if (rst || clear) begin
			code <= '0;
		end else if (valid) begin
			code <= code ^ contrib;
		end
	end

endmodule

//--- rtl/nand_host.sv
// Host-side sequencer that drives a byte-wide NAND flash through its pins.
//
// Contract
// - Address-to-data write strobe gap at least 100 ns.
// - Control and data change once per strobe low.
// - Scan markers, map out bad blocks first.
// - Never erase a factory bad marking.
// - Read status after program/erase, retire failures.
// - Replace via erased spare and page buffer; the spare search takes any scanned unmarked block, erased or not.
// - Apply error correction to all read data; read bytes go out raw, and errors are only flagged and located.
// - Single-bit correction, double-bit detection code.
// - Program pages in ascending order only; order is checked only within the last programmed block.
// - At most four partial programs per page; the count is kept only for the last programmed page.
`timescale 1ns/1ps
`include "nand_host_defines.svh"

module nand_host #(
	parameter int DATA_BYTES = 2048,
	parameter int NUM_BLOCKS = 1024,
	parameter int BLK_W = 10,
	parameter int PAGE_W = 6,
	parameter int IDX_W = $clog2(DATA_BYTES)
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire nand_host_pkg::op_e cmd_op,
	input wire logic [BLK_W-1:0] cmd_block,
	input wire logic [PAGE_W-1:0] cmd_page,
	output logic cmd_ready,
	input wire logic [7:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic done,
	output logic refused,
	output logic prog_fail,
	output logic ecc_corrected,
	output logic ecc_uncorrectable,
	output logic [IDX_W-1:0] err_byte,
	output logic [2:0] err_bit,
	output logic [BLK_W-1:0] spare_block,
	output logic spare_found,
	output logic ce_n,
	output logic cle,
	output logic ale,
	output logic we_n,
	output logic read_strobe_n,
	output logic write_protect_n,
	output logic [7:0] dq_out,
	output logic dq_oe,
	input wire logic [7:0] dq_in,
	input wire logic ready_busy_n
);

	localparam int CW = IDX_W + 4;
	localparam int ADL_MIN = `ADL_CYC;
	localparam logic [IDX_W:0] DATA_B = (IDX_W+1)'(DATA_BYTES);
	localparam logic [IDX_W:0] DATA_B1 = (IDX_W+1)'(DATA_BYTES + 1);
	localparam logic [IDX_W:0] DATA_B2 = (IDX_W+1)'(DATA_BYTES + 2);
	localparam logic [BLK_W-1:0] LAST_BLK = BLK_W'(NUM_BLOCKS - 1);

	nand_host_pkg::state_e state_reg, ret_reg;
	nand_host_pkg::op_e op_reg;
	logic [BLK_W-1:0] block_reg, prog_blk_reg, find_reg;
	logic [PAGE_W-1:0] page_reg, last_page_reg;
	logic [2:0] npp_reg;
	logic prog_valid_reg;
	logic [1:0] acnt_reg;
	logic [IDX_W:0] bcnt_reg;
	logic [3:0] wcnt_reg;
	logic [7:0] ecc_lo_reg, rd_byte_reg;
	logic [NUM_BLOCKS-1:0] bad_reg, scanned_reg;
	logic stb_busy_reg, stb_read_reg;
	logic [1:0] stb_cnt_reg;
	logic [CW-1:0] ecc_code;

	// ======================================================================
	// Decode
	wire in_idle = state_reg == nand_host_pkg::S_IDLE;
	wire in_cmd1 = state_reg == nand_host_pkg::S_CMD1;
	wire in_addr = state_reg == nand_host_pkg::S_ADDR;
	wire in_wdata = state_reg == nand_host_pkg::S_WDATA;
	wire in_cmd2 = state_reg == nand_host_pkg::S_CMD2;
	wire in_stcmd = state_reg == nand_host_pkg::S_STCMD;
	wire in_strd = state_reg == nand_host_pkg::S_STRD;
	wire in_rdata = state_reg == nand_host_pkg::S_RDATA;
	wire is_read = op_reg == nand_host_pkg::OP_READ;
	wire is_scan = op_reg == nand_host_pkg::OP_SCAN;
	wire is_prog = op_reg == nand_host_pkg::OP_PROG;
	wire is_erase = op_reg == nand_host_pkg::OP_ERASE;
	wire data_phase = bcnt_reg < DATA_B;
	wire stb_done = stb_busy_reg && (stb_cnt_reg == (stb_read_reg ? 2'h3 : 2'h2));
	wire accept = in_idle && cmd_valid && cmd_ready;
	wire take = in_wdata && wr_ready && wr_valid;

	// Only the spare marker column is read during a scan.
	wire [11:0] col_w = is_scan ? 12'(DATA_BYTES) : 12'h000;
	wire [15:0] row_w = 16'({block_reg, page_reg});
	wire [7:0] addr_byte = (acnt_reg == 2'h0) ? col_w[7:0] :
		(acnt_reg == 2'h1) ? {4'h0, col_w[11:8]} :
		(acnt_reg == 2'h2) ? row_w[7:0] : row_w[15:8];
	wire [7:0] cmd1_byte = (op_reg == nand_host_pkg::OP_RESET) ? `CMD_RESET :
		is_prog ? `CMD_PROG_SETUP : is_erase ? `CMD_ERASE_SETUP : `CMD_READ_SETUP;
	wire [7:0] cmd2_byte = is_prog ? `CMD_PROG_GO : is_erase ? `CMD_ERASE_GO : `CMD_READ_GO;
	wire [15:0] code_w = 16'(ecc_code);
	// The marker column is written as erased so a program never clears it.
	wire [7:0] wdata_byte = data_phase ? wr_data : (bcnt_reg == DATA_B) ? `ERASED_BYTE :
		(bcnt_reg == DATA_B1) ? code_w[7:0] : code_w[15:8];
	wire [7:0] stb_byte = in_cmd1 ? cmd1_byte : in_cmd2 ? cmd2_byte : in_stcmd ? `CMD_STATUS :
		in_addr ? addr_byte : wdata_byte;
	wire stb_cle = in_cmd1 || in_cmd2 || in_stcmd;
	wire stb_read = in_strd || in_rdata;
	wire wd_go = in_wdata && (data_phase ? take : 1'b1);
	wire stb_go = !stb_busy_reg && (in_cmd1 || in_cmd2 || in_stcmd || in_addr || stb_read || wd_go);

	// ======================================================================
	// Error detection and location on every page
	wire ecc_feed = take || (in_rdata && stb_done && data_phase && is_read);
	wire [15:0] stored_w = {rd_byte_reg, ecc_lo_reg};
	wire [CW-1:0] syn_w = stored_w[CW-1:0] ^ ecc_code;

	nand_ecc_acc #(.IDX_W(IDX_W)) ecc_inst (
		.clock(clock),
		.rst(rst),
		.clear(accept),
		.valid(ecc_feed),
		.data(take ? wr_data : rd_byte_reg),
		.idx(bcnt_reg[IDX_W-1:0]),
		.code(ecc_code)
	);

	// ======================================================================
	// Admission checks
	wire [BLK_W-1:0] next_blk = (cmd_block == LAST_BLK) ? '0 : cmd_block + 1'b1;
	wire same_blk = prog_valid_reg && (cmd_block == prog_blk_reg);
	wire order_bad = same_blk && ((cmd_page < last_page_reg) ||
		(cmd_page == last_page_reg && npp_reg == 3'(`MAX_PARTIAL)));
	wire erase_bad = !scanned_reg[cmd_block] || bad_reg[cmd_block];
	wire refuse = (cmd_op == nand_host_pkg::OP_ERASE && erase_bad) ||
		((cmd_op == nand_host_pkg::OP_PROG) && (bad_reg[cmd_block] || order_bad)) ||
		((cmd_op == nand_host_pkg::OP_READ) && bad_reg[cmd_block]);

	// ======================================================================
	// Strobe engine: write low two cycles, read low three cycles
	always_ff @(posedge clock) begin
		if (rst) begin
			we_n <= 1'b1;
			read_strobe_n <= 1'b1;
			cle <= 1'b0;
			ale <= 1'b0;
			dq_out <= 8'h00;
			dq_oe <= 1'b0;
			stb_busy_reg <= 1'b0;
			stb_read_reg <= 1'b0;
			stb_cnt_reg <= 2'h0;
			rd_byte_reg <= 8'h00;
		end else if (stb_go) begin
			// Lines move only on the edge that starts the low period.
			stb_busy_reg <= 1'b1;
			stb_read_reg <= stb_read;
			stb_cnt_reg <= 2'h0;
			we_n <= stb_read;
			read_strobe_n <= !stb_read;
			cle <= stb_cle;
			ale <= in_addr;
			dq_out <= stb_byte;
			dq_oe <= !stb_read;
		end else if (stb_busy_reg) begin
			stb_cnt_reg <= stb_cnt_reg + 2'h1;
			if (!stb_read_reg && stb_cnt_reg == 2'h1) begin
				we_n <= 1'b1;
			end
			if (stb_read_reg && stb_cnt_reg == 2'h2) begin
				read_strobe_n <= 1'b1;
				rd_byte_reg <= dq_in;
			end
			if (stb_done) begin
				stb_busy_reg <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Operation sequencer
	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= nand_host_pkg::S_IDLE;
			ret_reg <= nand_host_pkg::S_IDLE;
			op_reg <= nand_host_pkg::OP_RESET;
			block_reg <= '0;
			page_reg <= '0;
			acnt_reg <= 2'h0;
			bcnt_reg <= '0;
			wcnt_reg <= 4'h0;
			ecc_lo_reg <= 8'h00;
			bad_reg <= '0;
			scanned_reg <= '0;
			prog_valid_reg <= 1'b0;
			prog_blk_reg <= '0;
			last_page_reg <= '0;
			npp_reg <= 3'h0;
			find_reg <= '0;
			ce_n <= 1'b1;
			write_protect_n <= 1'b0;
			cmd_ready <= 1'b0;
			wr_ready <= 1'b0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
			done <= 1'b0;
			refused <= 1'b0;
			prog_fail <= 1'b0;
			ecc_corrected <= 1'b0;
			ecc_uncorrectable <= 1'b0;
			err_byte <= '0;
			err_bit <= 3'h0;
			spare_block <= '0;
			spare_found <= 1'b0;
		end else begin
			write_protect_n <= 1'b1;
			rd_valid <= 1'b0;
			done <= 1'b0;
			wr_ready <= take ? 1'b0 : (in_wdata && data_phase && !stb_busy_reg) ? 1'b1 : wr_ready;
			case (state_reg)
				nand_host_pkg::S_IDLE: begin
					cmd_ready <= !accept;
					if (accept) begin
						op_reg <= cmd_op;
						block_reg <= cmd_block;
						page_reg <= (cmd_op == nand_host_pkg::OP_SCAN) ? '0 : cmd_page;
						acnt_reg <= (cmd_op == nand_host_pkg::OP_ERASE) ? 2'h2 : 2'h0;
						bcnt_reg <= '0;
						refused <= 1'b0;
						prog_fail <= 1'b0;
						ecc_corrected <= 1'b0;
						ecc_uncorrectable <= 1'b0;
						spare_found <= 1'b0;
						if (refuse) begin
							refused <= 1'b1;
							state_reg <= nand_host_pkg::S_DONE;
						end else if (cmd_op == nand_host_pkg::OP_FIND) begin
							find_reg <= next_blk;
							state_reg <= nand_host_pkg::S_FIND;
						end else begin
							ce_n <= 1'b0;
							state_reg <= nand_host_pkg::S_CMD1;
						end
						if (!refuse && cmd_op == nand_host_pkg::OP_PROG) begin
							prog_valid_reg <= 1'b1;
							prog_blk_reg <= cmd_block;
							last_page_reg <= cmd_page;
							npp_reg <= (same_blk && cmd_page == last_page_reg) ? npp_reg + 3'h1 : 3'h1;
						end
						if (!refuse && cmd_op == nand_host_pkg::OP_ERASE && same_blk) begin
							prog_valid_reg <= 1'b0;
						end
					end
				end
				nand_host_pkg::S_CMD1: begin
					if (stb_done) begin
						if (op_reg == nand_host_pkg::OP_RESET) begin
							wcnt_reg <= 4'(`WB_CYC);
							ret_reg <= nand_host_pkg::S_BUSY;
							state_reg <= nand_host_pkg::S_WAIT;
						end else begin
							state_reg <= nand_host_pkg::S_ADDR;
						end
					end
				end
				nand_host_pkg::S_ADDR: begin
					if (stb_done) begin
						acnt_reg <= acnt_reg + 2'h1;
						if (acnt_reg == 2'h3 && is_prog) begin
							wcnt_reg <= 4'(`ADL_CYC);
							ret_reg <= nand_host_pkg::S_WDATA;
							state_reg <= nand_host_pkg::S_WAIT;
						end else if (acnt_reg == 2'h3) begin
							state_reg <= nand_host_pkg::S_CMD2;
						end
					end
				end
				nand_host_pkg::S_WDATA: begin
					if (stb_done) begin
						bcnt_reg <= bcnt_reg + 1'b1;
						if (bcnt_reg == DATA_B2) begin
							state_reg <= nand_host_pkg::S_CMD2;
						end
					end
				end
				nand_host_pkg::S_CMD2: begin
					if (stb_done) begin
						wcnt_reg <= 4'(`WB_CYC);
						ret_reg <= nand_host_pkg::S_BUSY;
						state_reg <= nand_host_pkg::S_WAIT;
					end
				end
				nand_host_pkg::S_BUSY: begin
					// Nothing further is sent until the device reports ready.
					if (ready_busy_n) begin
						bcnt_reg <= '0;
						if (op_reg == nand_host_pkg::OP_RESET) begin
							state_reg <= nand_host_pkg::S_DONE;
						end else if (is_read || is_scan) begin
							wcnt_reg <= 4'(`RR_CYC);
							ret_reg <= nand_host_pkg::S_RDATA;
							state_reg <= nand_host_pkg::S_WAIT;
						end else begin
							state_reg <= nand_host_pkg::S_STCMD;
						end
					end
				end
				nand_host_pkg::S_STCMD: begin
					if (stb_done) begin
						wcnt_reg <= 4'(`WHR_CYC);
						ret_reg <= nand_host_pkg::S_STRD;
						state_reg <= nand_host_pkg::S_WAIT;
					end
				end
				nand_host_pkg::S_STRD: begin
					if (stb_done) begin
						prog_fail <= rd_byte_reg[`STATUS_FAIL_BIT];
						if (rd_byte_reg[`STATUS_FAIL_BIT]) begin
							bad_reg[block_reg] <= 1'b1;
						end
						state_reg <= nand_host_pkg::S_DONE;
					end
				end
				nand_host_pkg::S_RDATA: begin
					if (stb_done) begin
						bcnt_reg <= bcnt_reg + 1'b1;
						if (is_scan) begin
							if (rd_byte_reg != `ERASED_BYTE || page_reg != '0) begin
								bad_reg[block_reg] <= bad_reg[block_reg] || (rd_byte_reg != `ERASED_BYTE);
								scanned_reg[block_reg] <= 1'b1;
								state_reg <= nand_host_pkg::S_DONE;
							end else begin
								page_reg <= PAGE_W'(1);
								acnt_reg <= 2'h0;
								wcnt_reg <= 4'(`RHW_CYC);
								ret_reg <= nand_host_pkg::S_CMD1;
								state_reg <= nand_host_pkg::S_WAIT;
							end
						end else begin
							if (data_phase) begin
								rd_data <= rd_byte_reg;
								rd_valid <= 1'b1;
							end
							if (bcnt_reg == DATA_B1) begin
								ecc_lo_reg <= rd_byte_reg;
							end
							if (bcnt_reg == DATA_B2) begin
								ecc_corrected <= syn_w[CW-1];
								ecc_uncorrectable <= !syn_w[CW-1] && (syn_w != '0);
								err_byte <= syn_w[CW-2:3];
								err_bit <= syn_w[2:0];
								state_reg <= nand_host_pkg::S_DONE;
							end
						end
					end
				end
				nand_host_pkg::S_WAIT: begin
					wcnt_reg <= wcnt_reg - 4'h1;
					if (wcnt_reg <= 4'h1) begin
						state_reg <= ret_reg;
					end
				end
				nand_host_pkg::S_FIND: begin
					// Linear search is slow but costs no extra table.
					if (!bad_reg[find_reg] && scanned_reg[find_reg]) begin
						spare_found <= 1'b1;
						spare_block <= find_reg;
						state_reg <= nand_host_pkg::S_DONE;
					end else if (find_reg == block_reg) begin
						state_reg <= nand_host_pkg::S_DONE;
					end else begin
						find_reg <= (find_reg == LAST_BLK) ? '0 : find_reg + 1'b1;
					end
				end
				nand_host_pkg::S_DONE: begin
					done <= 1'b1;
					ce_n <= 1'b1;
					state_reg <= nand_host_pkg::S_IDLE;
				end
				default: begin
					state_reg <= nand_host_pkg::S_IDLE;
				end
			endcase
		end
	end

	// ======================================================================
	// Checks
	logic [4:0] adl_cnt_reg;
	logic adl_arm_reg;
	always_ff @(posedge clock) begin
		if (rst) begin
			adl_cnt_reg <= 5'h00;
			adl_arm_reg <= 1'b0;
		end else if (!$past(we_n) && we_n) begin
			adl_cnt_reg <= 5'h00;
			adl_arm_reg <= ale;
		end else if (adl_cnt_reg != 5'h1F) begin
			adl_cnt_reg <= adl_cnt_reg + 5'h01;
		end
	end

	AST_ADDR_TO_DATA_GAP: assert property (@(posedge clock) disable iff (rst)
		($rose(we_n) && !cle && !ale && adl_arm_reg) |-> (adl_cnt_reg >= 5'(ADL_MIN - 1)))
		else $error("data strobe too soon after last address strobe");
	AST_LINES_HOLD_LOW: assert property (@(posedge clock) disable iff (rst)
		(!we_n && !$past(we_n)) |-> $stable({cle, ale, ce_n, dq_out}))
		else $error("control or data changed during write strobe low");
	AST_WE_PULSE: assert property (@(posedge clock) disable iff (rst)
		$fell(we_n) |=> !we_n ##1 we_n)
		else $error("write strobe low period not two cycles");
	AST_NO_CMD_WHILE_BUSY: assert property (@(posedge clock) disable iff (rst)
		(stb_go && state_reg == nand_host_pkg::S_CMD1) |-> ready_busy_n)
		else $error("command issued while device busy");
	AST_NO_ERASE_BAD: assert property (@(posedge clock) disable iff (rst)
		(in_cmd1 && is_erase) |-> (!bad_reg[block_reg] && scanned_reg[block_reg]))
		else $error("erase started on marked or unscanned block");
	AST_STATUS_AFTER_WRITE: assert property (@(posedge clock) disable iff (rst)
		(state_reg == nand_host_pkg::S_BUSY && ready_busy_n && (is_prog || is_erase))
		|=> in_stcmd ##[1:4] (in_stcmd && stb_busy_reg && cle && dq_out == `CMD_STATUS))
		else $error("status not read after program or erase");
	AST_RETIRE_ON_FAIL: assert property (@(posedge clock) disable iff (rst)
		(in_strd && stb_done && rd_byte_reg[`STATUS_FAIL_BIT]) |=> (bad_reg[block_reg] && prog_fail) ##1 done)
		else $error("failed block not retired");
	AST_PROG_ORDER: assert property (@(posedge clock) disable iff (rst)
		(accept && cmd_op == nand_host_pkg::OP_PROG && same_blk && cmd_page < last_page_reg)
		|=> (state_reg == nand_host_pkg::S_DONE && refused && ce_n))
		else $error("descending page program not refused");
	AST_PARTIAL_LIMIT: assert property (@(posedge clock) disable iff (rst)
		(accept && cmd_op == nand_host_pkg::OP_PROG && same_blk && cmd_page == last_page_reg &&
		npp_reg == 3'(`MAX_PARTIAL)) |=> refused ##1 done)
		else $error("fifth partial program not refused");

endmodule

//--- rtl/nand_host_defines.svh
// Timing counts, command bytes and marker values for the flash host sequencer.
`ifndef NAND_HOST_DEFINES_SVH
`define NAND_HOST_DEFINES_SVH

// ==========================================================================
// Clock and pin timing
`define CLK_PERIOD_NS 10
`define CYC_MIN(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_ADL_NS 100
`define T_WB_NS 100
`define T_WHR_NS 60
`define T_RR_NS 20
`define T_RHW_NS 100
`define ADL_CYC `CYC_MIN(`T_ADL_NS)
`define WB_CYC `CYC_MIN(`T_WB_NS)
`define WHR_CYC `CYC_MIN(`T_WHR_NS)
`define RR_CYC `CYC_MIN(`T_RR_NS)
`define RHW_CYC `CYC_MIN(`T_RHW_NS)

// ==========================================================================
// Command bytes and status layout
`define CMD_RESET 8'hFF
`define CMD_READ_SETUP 8'h00
`define CMD_READ_GO 8'h30
`define CMD_PROG_SETUP 8'h80
`define CMD_PROG_GO 8'h10
`define CMD_ERASE_SETUP 8'h60
`define CMD_ERASE_GO 8'hD0
`define CMD_STATUS 8'h70
`define STATUS_FAIL_BIT 0

// ==========================================================================
// Media values
`define ERASED_BYTE 8'hFF
`define MAX_PARTIAL 4

`endif

//--- rtl/nand_host_pkg.sv
// Types shared by the flash host sequencer.
package nand_host_pkg;

	// ======================================================================
	// Operations and sequencer states
	typedef enum logic [2:0] {
		OP_RESET = 3'h0,
		OP_READ = 3'h1,
		OP_PROG = 3'h2,
		OP_ERASE = 3'h3,
		OP_SCAN = 3'h4,
		OP_FIND = 3'h5
	} op_e;

	typedef enum logic [11:0] {
		S_IDLE = 12'h001,
		S_CMD1 = 12'h002,
		S_ADDR = 12'h004,
		S_WDATA = 12'h008,
		S_CMD2 = 12'h010,
		S_BUSY = 12'h020,
		S_STCMD = 12'h040,
		S_STRD = 12'h080,
		S_RDATA = 12'h100,
		S_WAIT = 12'h200,
		S_FIND = 12'h400,
		S_DONE = 12'h800
	} state_e;

endpackage

//--- verif/flash_model.sv
// Behavioural byte-wide flash device that answers the host sequencer's pins.
`timescale 1ns/1ps

module flash_model #(
	parameter int DATA_BYTES = 16,
	parameter int BUSY_CYC = 40
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic read_strobe_n,
	input wire logic [7:0] host_dq,
	input wire logic fail_next,
	input wire logic [7:0] flip_col,
	input wire logic [7:0] flip_mask,
	output logic [7:0] dev_dq,
	output logic ready_busy_n,
	output int viol
);
	logic [7:0] mem [int], pbuf [int];
	int nop [int], last_pg [int];
	logic [7:0] cmd = 8'h00, cur;
	logic fail_st = 1'b0, we_d = 1'b1, re_d = 1'b1, in_data = 1'b0;
	logic [10:0] lines_d;
	int busy = 0, acnt = 0, col = 0, row = 0, t_addr = 0, cyc = 0, base;

	// Unwritten locations read erased.
	function automatic logic [7:0] rd(input int key);
		return mem.exists(key) ? mem[key] : 8'hFF;
	endfunction

	// ======================================================================
	// Factory marking on the second page of block two only
	initial begin
		mem[(2 * 64 + 1) * 32 + DATA_BYTES] = 8'h00;
		ready_busy_n = 1'b1;
		cur = 8'h00;
		viol = 0;
	end

	// A released bus shows the inverse so a stale byte never passes as data.
	assign dev_dq = (!read_strobe_n && !ce_n) ? cur : ~cur;

	// ======================================================================
	// Latch cycles, busy time and the host-side referee checks
	always @(posedge clock) begin
		cyc++;
		if (busy > 0) busy--;
		if (rst) busy = 0;
		if (!we_n && !we_d && lines_d != {cle, ale, ce_n, host_dq}) viol++;
		if (read_strobe_n && !re_d && cmd != 8'h70) col++;
		if (we_n && !we_d && !ce_n) begin
			if (busy > 0 && !(cle && (host_dq == 8'h70 || host_dq == 8'hFF))) viol++;
			if (cle) begin
				cmd = host_dq;
				acnt = (host_dq == 8'h60) ? 2 : 0;
				in_data = 1'b0;
				base = row - row % 64;
				case (host_dq)
					8'hFF: busy = BUSY_CYC;
					8'h30: busy = BUSY_CYC;
					8'h80: pbuf.delete();
					8'h10: begin
						if (last_pg.exists(row / 64) && row % 64 < last_pg[row / 64]) viol++;
						nop[row] = (nop.exists(row) ? nop[row] : 0) + 1;
						if (nop[row] > 4) viol++;
						last_pg[row / 64] = row % 64;
						fail_st = fail_next;
						if (!fail_next) foreach (pbuf[c]) mem[row * 32 + c] = rd(row * 32 + c) & pbuf[c];
						busy = BUSY_CYC;
					end
					8'hD0: begin
						if (rd(base * 32 + DATA_BYTES) != 8'hFF || rd(base * 32 + 32 + DATA_BYTES) != 8'hFF) viol++;
						for (int k = base * 32; k < base * 32 + 2048; k++) begin
							mem.delete(k);
							nop.delete(k / 32);
						end
						last_pg.delete(row / 64);
						fail_st = fail_next;
						busy = BUSY_CYC;
					end
					default: ;
				endcase
			end else if (ale) begin
				case (acnt)
					0: col = host_dq;
					1: col += host_dq * 256;
					2: row = host_dq;
					default: row += host_dq * 256;
				endcase
				acnt++;
				t_addr = cyc;
				in_data = 1'b1;
			end else begin
				if (in_data && cyc - t_addr < 10) viol++;
				in_data = 1'b0;
				pbuf[col] = host_dq;
				col++;
			end
		end
		we_d = we_n;
		re_d = read_strobe_n;
		lines_d = {cle, ale, ce_n, host_dq};
		ready_busy_n <= (busy == 0);
		cur <= (cmd == 8'h70) ? {7'h60, fail_st} : rd(row * 32 + col) ^ (col == flip_col ? flip_mask : 8'h00);
	end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the flash host sequencer against the device model.
`timescale 1ns/1ps

module testbench;
	localparam int DB = 16;
	logic clock, rst, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, done, refused, prog_fail;
	logic ecc_corrected, ecc_uncorrectable, spare_found, ce_n, cle, ale, we_n, read_strobe_n;
	logic write_protect_n, dq_oe, ready_busy_n, fail_next;
	nand_host_pkg::op_e cmd_op;
	logic [1:0] cmd_block, spare_block;
	logic [5:0] cmd_page;
	logic [7:0] wr_data, rd_data, dq_out, dev_dq, flip_col, flip_mask;
	logic [7:0] rbuf [DB];
	logic [3:0] err_byte;
	logic [2:0] err_bit;
	wire logic [7:0] bus;
	int viol, nrd, bad_count = 0, num_checks = 0, cyc = 0;

	assign bus = dq_oe ? dq_out : dev_dq;

	nand_host #(.DATA_BYTES(DB), .NUM_BLOCKS(4), .BLK_W(2), .PAGE_W(6)) dut (.clock(clock), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_block(cmd_block), .cmd_page(cmd_page),
		.cmd_ready(cmd_ready), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.rd_data(rd_data), .rd_valid(rd_valid), .done(done), .refused(refused), .prog_fail(prog_fail),
		.ecc_corrected(ecc_corrected), .ecc_uncorrectable(ecc_uncorrectable), .err_byte(err_byte),
		.err_bit(err_bit), .spare_block(spare_block), .spare_found(spare_found), .ce_n(ce_n), .cle(cle),
		.ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n), .write_protect_n(write_protect_n),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(bus), .ready_busy_n(ready_busy_n));

	flash_model #(.DATA_BYTES(DB), .BUSY_CYC(40)) partner (.clock(clock), .rst(rst), .ce_n(ce_n), .cle(cle),
		.ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n), .host_dq(dq_out), .fail_next(fail_next),
		.flip_col(flip_col), .flip_mask(flip_mask), .dev_dq(dev_dq), .ready_busy_n(ready_busy_n), .viol(viol));

	// ======================================================================
	// Comparisons and the closing report
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		chk_val({15'h0000, got}, {15'h0000, exp});
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	function automatic logic [7:0] pat(input int blk, input int k);
		return 8'(k * 29 + blk * 7 + 3);
	endfunction

	// ======================================================================
	// One command from request to done; program bytes fed, read bytes kept
	task automatic run(input nand_host_pkg::op_e op, input int blk, input int pg);
		int k;
		k = 0;
		nrd = 0;
		cmd_op <= op;
		cmd_block <= 2'(blk);
		cmd_page <= 6'(pg);
		cmd_valid <= 1'b1;
		wr_data <= pat(blk, 0);
		wr_valid <= (op == nand_host_pkg::OP_PROG);
		do @(posedge clock); while (!(cmd_valid && cmd_ready));
		cmd_valid <= 1'b0;
		while (done !== 1'b1) begin
			if (wr_valid && wr_ready) begin
				k++;
				wr_data <= pat(blk, k);
				if (k == DB) wr_valid <= 1'b0;
			end
			if (rd_valid === 1'b1 && nrd < DB) begin
				rbuf[nrd] = rd_data;
				nrd++;
			end
			@(posedge clock);
		end
	endtask

	// The flip models a cell fault on one byte; the stream is raw, so it shows.
	task automatic check_read(input int blk, input int fcol, input logic [7:0] fm, input logic corr, input logic unc);
		flip_col <= 8'(fcol);
		flip_mask <= fm;
		run(nand_host_pkg::OP_READ, blk, 0);
		flip_mask <= 8'h00;
		chk_val(16'(nrd), 16'(DB));
		for (int k = 0; k < DB; k++) chk_val(16'(rbuf[k]), 16'(pat(blk, k) ^ (k == fcol ? fm : 8'h00)));
		chk_flag(ecc_corrected, corr);
		chk_flag(ecc_uncorrectable, unc);
	endtask

	// ======================================================================
	// Scenarios
	task automatic t_scan();
		run(nand_host_pkg::OP_ERASE, 1, 0);
		chk_flag(refused, 1'b1);
		run(nand_host_pkg::OP_RESET, 0, 0);
		chk_flag(refused, 1'b0);
		for (int b = 0; b < 4; b++) run(nand_host_pkg::OP_SCAN, b, 0);
		run(nand_host_pkg::OP_ERASE, 2, 0);
		chk_flag(refused, 1'b1);
		run(nand_host_pkg::OP_READ, 2, 0);
		chk_flag(refused, 1'b1);
		run(nand_host_pkg::OP_ERASE, 1, 0);
		chk_flag(refused, 1'b0);
		chk_flag(prog_fail, 1'b0);
	endtask

	task automatic t_data();
		run(nand_host_pkg::OP_PROG, 1, 0);
		chk_flag(prog_fail, 1'b0);
		chk_flag(write_protect_n, 1'b1);
		check_read(1, 0, 8'h00, 1'b0, 1'b0);
		check_read(1, 3, 8'h10, 1'b1, 1'b0);
		chk_val(16'(err_byte), 16'h0003);
		chk_val(16'(err_bit), 16'h0004);
		check_read(1, 5, 8'h12, 1'b0, 1'b1);
	endtask

	task automatic t_order();
		for (int i = 0; i < 4; i++) begin
			run(nand_host_pkg::OP_PROG, 1, 0);
			chk_flag(refused, i == 3);
		end
		run(nand_host_pkg::OP_PROG, 1, 2);
		chk_flag(refused, 1'b0);
		run(nand_host_pkg::OP_PROG, 1, 1);
		chk_flag(refused, 1'b1);
	endtask

	task automatic t_fail();
		fail_next <= 1'b1;
		run(nand_host_pkg::OP_PROG, 3, 0);
		fail_next <= 1'b0;
		chk_flag(prog_fail, 1'b1);
		run(nand_host_pkg::OP_PROG, 3, 1);
		chk_flag(refused, 1'b1);
		run(nand_host_pkg::OP_FIND, 1, 0);
		chk_flag(spare_found, 1'b1);
		chk_val(16'(spare_block), 16'h0000);
		run(nand_host_pkg::OP_PROG, 0, 0);
		chk_flag(prog_fail, 1'b0);
		check_read(0, 0, 8'h00, 1'b0, 1'b0);
	endtask

	// ======================================================================
	// Clock, watchdog and main sequence
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Whole run needs well under ten thousand cycles; the ceiling leaves margin.
	always @(posedge clock) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			$display("ERROR t=%0t run did not finish", $time);
			wrap_up();
		end
	end

	initial begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = nand_host_pkg::OP_RESET;
		cmd_block = 2'h0;
		cmd_page = 6'h00;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		fail_next = 1'b0;
		flip_col = 8'h00;
		flip_mask = 8'h00;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		t_scan();
		t_data();
		t_order();
		t_fail();
		chk_val(16'(viol), 16'h0000);
		wrap_up();
	end
endmodule
